/* File: src/pbc_pkg.sv */
// Package for the power budgeting capability register bank
package pbc_pkg;

	// Register byte offsets
	localparam logic [11:0] PBC_OFF_HEADER = 12'h280;
	localparam logic [11:0] PBC_OFF_SELECT = 12'h284;
	localparam logic [11:0] PBC_OFF_WINDOW = 12'h288;
	localparam logic [11:0] PBC_OFF_FLAG = 12'h28C;
	localparam logic [11:0] PBC_OFF_VALUE0 = 12'h300;
	localparam logic [11:0] PBC_OFF_VALUE_END = 12'h320;
	localparam logic [11:0] PBC_OFF_SWITCH_CONTROL = 12'h404;

	// Power data value registers
	localparam int PBC_VALUE_COUNT = 8;
	localparam logic [7:0] PBC_VALUE_LAST = 8'h07;

	// Header field positions
	localparam int PBC_ID_LSB = 0;
	localparam int PBC_ID_MSB = 15;
	localparam int PBC_VER_LSB = 16;
	localparam int PBC_VER_MSB = 19;
	localparam int PBC_NXT_LSB = 20;
	localparam int PBC_NXT_MSB = 31;

	// Selector and flag positions
	localparam int PBC_SEL_MSB = 7;
	localparam int PBC_ALLOC_BIT = 0;

	// Switch control bit positions
	localparam int PBC_CTL_VALUE_UNLOCK = 0;
	localparam int PBC_CTL_CAP_UNLOCK = 1;

	// Reset values
	localparam logic [15:0] PBC_RST_ID = 16'h0000;
	localparam logic [3:0] PBC_RST_VER = 4'h0;
	localparam logic [11:0] PBC_RST_NXT = 12'h000;
	localparam logic [7:0] PBC_RST_SEL = 8'h00;
	localparam logic [31:0] PBC_RST_WORD = 32'h0000_0000;

	// Write from the initialization loader, bypasses all locks
	typedef struct packed {
		logic wr;
		logic [11:0] addr;
		logic [31:0] data;
	} pbc_init_s;

endpackage

/* File: src/pbc_regs.sv */
// Power budgeting capability register bank with APB slave
//
// Functional notes
// - Header bits 15:0 hold identifier, 0x4 expected
// - Header bits 19:16 hold version, 0x1 expected
// - Selector bits 7:0, read/write, resets zero
// - Selector above seven gives zero window
// - Window is read-only, shows selected value
// - System-allocated flag bit 0, resets zero
// - Eight values at 0x300, writable only unlocked
//
// Decided for this implementation: the APB slave port.
`timescale 1ns/100ps

module pbc_regs (
	// Clock and reset
	input logic pclk,
	input logic presetn,
	// APB slave
	input logic psel,
	input logic penable,
	input logic pwrite,
	input logic [11:0] paddr,
	input logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Initialization loader
	input pbc_pkg::pbc_init_s init_req,
	// Flag to the budgeting logic
	output logic system_allocated
);
	import pbc_pkg::*;

	logic [15:0] structure_identifier;
	logic [3:0] structure_version;
	logic [11:0] next_structure_pointer;
	logic [7:0] value_index;
	logic value_write_unlock;
	logic cap_write_unlock;
	logic [31:0] power_data_value [PBC_VALUE_COUNT];

	logic setup;
	logic wr_go;
	logic [31:0] header_word;
	logic [31:0] win_value;
	logic [31:0] next_rdata;
	logic next_err;
	logic [31:0] next_value [PBC_VALUE_COUNT];

	function automatic logic is_value(input logic [11:0] a);
		return (a >= PBC_OFF_VALUE0) && (a < PBC_OFF_VALUE_END) && (a[1:0] == 2'h0);
	endfunction

	function automatic logic [2:0] value_slot(input logic [11:0] a);
		return a[4:2];
	endfunction

	assign setup = psel & ~penable;
	assign wr_go = psel & penable & pready & pwrite;
	assign header_word = {next_structure_pointer, structure_version, structure_identifier};

	// Window shows the selected value or zero past the last one
	always_comb begin
		if (value_index > PBC_VALUE_LAST) begin
			win_value = 32'h0000_0000;
		end else begin
			win_value = power_data_value[value_index[2:0]];
		end
	end

	// Read decode, unmapped addresses answer with an error
	always_comb begin
		next_rdata = 32'h0000_0000;
		next_err = 1'b0;
		case (paddr)
			PBC_OFF_HEADER: next_rdata = header_word;
			PBC_OFF_SELECT: next_rdata = {24'h00_0000, value_index};
			PBC_OFF_WINDOW: next_rdata = win_value;
			PBC_OFF_FLAG: next_rdata = {31'h0, system_allocated};
			PBC_OFF_SWITCH_CONTROL: next_rdata = {30'h0, cap_write_unlock, value_write_unlock};
			default: begin
				if (is_value(paddr)) begin
					next_rdata = power_data_value[value_slot(paddr)];
				end else begin
					next_err = 1'b1;
				end
			end
		endcase
	end

	// APB answer: one wait-free access phase, data captured in setup
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			prdata <= PBC_RST_WORD;
			pslverr <= 1'b0;
		end else begin
			pready <= setup;
			pslverr <= setup & next_err;
			prdata <= (setup & ~pwrite) ? next_rdata : PBC_RST_WORD;
		end
	end

	// Lockable header: loader wins over an unlocked APB write
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			structure_identifier <= PBC_RST_ID;
			structure_version <= PBC_RST_VER;
			next_structure_pointer <= PBC_RST_NXT;
		end else if (init_req.wr && init_req.addr == PBC_OFF_HEADER) begin
			structure_identifier <= init_req.data[PBC_ID_MSB:PBC_ID_LSB];
			structure_version <= init_req.data[PBC_VER_MSB:PBC_VER_LSB];
			next_structure_pointer <= init_req.data[PBC_NXT_MSB:PBC_NXT_LSB];
		end else if (wr_go && paddr == PBC_OFF_HEADER && cap_write_unlock) begin
			structure_identifier <= pwdata[PBC_ID_MSB:PBC_ID_LSB];
			structure_version <= pwdata[PBC_VER_MSB:PBC_VER_LSB];
			next_structure_pointer <= pwdata[PBC_NXT_MSB:PBC_NXT_LSB];
		end
	end

	// Selector, plain read/write
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			value_index <= PBC_RST_SEL;
		end else if (wr_go && paddr == PBC_OFF_SELECT) begin
			value_index <= pwdata[PBC_SEL_MSB:0];
		end
	end

	// System-allocated flag, lockable
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			system_allocated <= 1'b0;
		end else if (init_req.wr && init_req.addr == PBC_OFF_FLAG) begin
			system_allocated <= init_req.data[PBC_ALLOC_BIT];
		end else if (wr_go && paddr == PBC_OFF_FLAG && cap_write_unlock) begin
			system_allocated <= pwdata[PBC_ALLOC_BIT];
		end
	end

	// Switch control unlock bits
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			value_write_unlock <= 1'b0;
			cap_write_unlock <= 1'b0;
		end else if (init_req.wr && init_req.addr == PBC_OFF_SWITCH_CONTROL) begin
			value_write_unlock <= init_req.data[PBC_CTL_VALUE_UNLOCK];
			cap_write_unlock <= init_req.data[PBC_CTL_CAP_UNLOCK];
		end else if (wr_go && paddr == PBC_OFF_SWITCH_CONTROL) begin
			value_write_unlock <= pwdata[PBC_CTL_VALUE_UNLOCK];
			cap_write_unlock <= pwdata[PBC_CTL_CAP_UNLOCK];
		end
	end

	// Next value of each data word; locked APB writes are dropped
	always_comb begin
		for (int i = 0; i < PBC_VALUE_COUNT; i++) begin
			next_value[i] = power_data_value[i];
			if (init_req.wr && is_value(init_req.addr)
					&& value_slot(init_req.addr) == i[2:0]) begin
				next_value[i] = init_req.data;
			end else if (wr_go && is_value(paddr) && value_slot(paddr) == i[2:0]
					&& value_write_unlock) begin
				next_value[i] = pwdata;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int i = 0; i < PBC_VALUE_COUNT; i++) begin
				power_data_value[i] <= PBC_RST_WORD;
			end
		end else begin
			for (int i = 0; i < PBC_VALUE_COUNT; i++) begin
				power_data_value[i] <= next_value[i];
			end
		end
	end

	// Helpers for the checks below
	logic [2:0] hold_idx;
	logic [31:0] hold_val;
	logic [15:0] init_id;
	logic [3:0] init_ver;
	logic [7:0] wr_sel;
	logic wr_alloc;
	logic loader_idle;

	assign init_id = init_req.data[PBC_ID_MSB:PBC_ID_LSB];
	assign init_ver = init_req.data[PBC_VER_MSB:PBC_VER_LSB];
	assign wr_sel = pwdata[PBC_SEL_MSB:0];
	assign wr_alloc = pwdata[PBC_ALLOC_BIT];
	assign loader_idle = ~init_req.wr;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			hold_idx <= 3'h0;
			hold_val <= PBC_RST_WORD;
		end else begin
			hold_idx <= value_slot(paddr);
			hold_val <= power_data_value[value_slot(paddr)];
		end
	end

	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	a_ident_load: assert property (
		init_req.wr && init_req.addr == PBC_OFF_HEADER
		|=> structure_identifier == $past(init_id))
		else $error("identifier field not loaded from bits 15:0");

	a_version_load: assert property (
		init_req.wr && init_req.addr == PBC_OFF_HEADER
		|=> header_word[PBC_VER_MSB:PBC_VER_LSB] == $past(init_ver))
		else $error("version field not loaded from bits 19:16");

	a_select_write: assert property (
		wr_go && paddr == PBC_OFF_SELECT
		|=> value_index == $past(wr_sel) ##1 value_index == $past(wr_sel, 2))
		else $error("selector write not stored");

	a_window_zero: assert property (
		setup && !pwrite && paddr == PBC_OFF_WINDOW && value_index > 8'h07
		|=> pready && prdata == 32'h0000_0000)
		else $error("window not zero for selector above seven");

	a_window_value: assert property (
		setup && !pwrite && paddr == PBC_OFF_WINDOW
		|=> pready && !pslverr && prdata == $past(win_value))
		else $error("window does not show selected value");

	a_flag_read: assert property (
		setup && !pwrite && paddr == PBC_OFF_FLAG
		|=> prdata == {31'h0, $past(system_allocated)})
		else $error("flag read does not show bit 0");

	a_flag_unlocked: assert property (
		wr_go && paddr == PBC_OFF_FLAG && cap_write_unlock && loader_idle
		|=> system_allocated == $past(wr_alloc))
		else $error("unlocked flag write not stored");

	a_value_locked: assert property (
		wr_go && is_value(paddr) && !value_write_unlock && loader_idle
		|=> power_data_value[hold_idx] == hold_val)
		else $error("locked data value was written");

	a_value_unlocked: assert property (
		wr_go && is_value(paddr) && value_write_unlock && loader_idle
		|=> power_data_value[hold_idx] == $past(pwdata))
		else $error("unlocked data value write not stored");

	a_header_locked: assert property (
		wr_go && paddr == PBC_OFF_HEADER && !cap_write_unlock && loader_idle
		|=> $stable(header_word))
		else $error("locked header changed by bus write");

	a_ready_pulse: assert property (
		setup |=> pready ##1 !pready)
		else $error("ready is not a single access-phase pulse");

endmodule

/* File: verification/tb.sv */
// Self-checking testbench for the power budgeting register bank
`timescale 1ns/100ps

module tb;
	import pbc_pkg::*;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	pbc_init_s init_req = '0;
	logic system_allocated;
	int errors = 0;
	int n_tests = 0;
	logic [31:0] rd;
	logic er;

	always #5 pclk = ~pclk;

	pbc_regs pbc_regs_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .init_req(init_req), .system_allocated(system_allocated));

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			errors++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// Answer is taken at the rising edge where pready is seen high; the watchdog ends a hang
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	// Flag is looked at mid-cycle, once the access edge has settled it
	task automatic flag_chk(input logic exp);
		@(negedge pclk);
		chk(32'(system_allocated), 32'(exp));
	endtask

	task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0000_0000);
		chk(rd, exp);
	endtask

	task automatic load(input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		init_req <= '{wr: 1'b1, addr: a, data: d};
		@(posedge pclk);
		init_req <= '0;
	endtask

	task automatic t_reset;
		rdchk(PBC_OFF_HEADER, PBC_RST_WORD);
		rdchk(PBC_OFF_SELECT, 32'h0000_0000);
		rdchk(PBC_OFF_WINDOW, 32'h0000_0000);
		rdchk(PBC_OFF_FLAG, 32'h0000_0000);
		flag_chk(1'b0);
		$display("reset values done");
	endtask

	task automatic t_loader;
		load(PBC_OFF_HEADER, 32'h0001_0004);
		load(PBC_OFF_FLAG, 32'h0000_0001);
		rdchk(PBC_OFF_HEADER, 32'h0001_0004);
		rdchk(PBC_OFF_FLAG, 32'h0000_0001);
		flag_chk(1'b1);
		apb(1'b1, PBC_OFF_HEADER, 32'hFFFF_FFFF);
		apb(1'b1, PBC_OFF_FLAG, 32'h0000_0000);
		rdchk(PBC_OFF_HEADER, 32'h0001_0004);
		flag_chk(1'b1);
		apb(1'b1, PBC_OFF_WINDOW, 32'h1234_5678);
		rdchk(PBC_OFF_WINDOW, 32'h0000_0000);
		$display("loader and locks done");
	endtask

	task automatic t_values;
		apb(1'b1, PBC_OFF_VALUE0, 32'hA5A5_0000);
		rdchk(PBC_OFF_WINDOW, 32'h0000_0000);
		apb(1'b1, PBC_OFF_SWITCH_CONTROL, 32'h0000_0001);
		for (int k = 0; k < 8; k++) apb(1'b1, PBC_OFF_VALUE0 + 12'(4 * k), 32'h5A00_0010 + k);
		for (int k = 0; k < 9; k++) begin
			apb(1'b1, PBC_OFF_SELECT, 32'(k));
			rdchk(PBC_OFF_SELECT, 32'(k));
			rdchk(PBC_OFF_WINDOW, (k < 8) ? 32'h5A00_0010 + k : 32'h0);
		end
		apb(1'b1, PBC_OFF_SELECT, 32'h0000_01FF);
		rdchk(PBC_OFF_SELECT, 32'h0000_00FF);
		rdchk(PBC_OFF_WINDOW, 32'h0000_0000);
		apb(1'b1, PBC_OFF_SWITCH_CONTROL, 32'h0000_0000);
		apb(1'b1, PBC_OFF_VALUE0 + 12'h00C, 32'h0000_0000);
		apb(1'b1, PBC_OFF_SELECT, 32'h0000_0003);
		rdchk(PBC_OFF_WINDOW, 32'h5A00_0013);
		$display("data values done");
	endtask

	task automatic t_unlock;
		apb(1'b1, PBC_OFF_SWITCH_CONTROL, 32'h0000_0002);
		apb(1'b1, PBC_OFF_HEADER, 32'h1231_0004);
		rdchk(PBC_OFF_HEADER, 32'h1231_0004);
		apb(1'b1, PBC_OFF_FLAG, 32'h0000_0000);
		flag_chk(1'b0);
		apb(1'b0, 12'h290, 32'h0000_0000);
		chk(32'(er), 32'h1);
		chk(rd, 32'h0000_0000);
		$display("unlock and unmapped done");
	endtask

	task automatic results;
		$display("comparisons %0d mismatches %0d", n_tests, errors);
		if (errors == 0 && n_tests > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	initial begin
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		t_reset();
		t_loader();
		t_values();
		t_unlock();
		results();
	end

	initial begin
		#50000;
		errors++;
		results();
	end
endmodule
